/* File: core/hnc_pkg.sv */
// Overview of operation
// - Low four bits select NCO filter cutoff
// - Code 0 is 250 kHz, 0xF 7.6 Hz
// - Timer field is averaging period in ms
// - Timer resets to ten milliseconds
// - Offset limited by 24-bit clamp value
package hnc_pkg;
  // ==========================================================
  // Register offsets
  localparam logic [15:0] HNC_OFS_CLAMP_HIGH = 16'h1008;
  localparam logic [15:0] HNC_OFS_FILTER_BW = 16'h1009;
  localparam logic [15:0] HNC_OFS_PERIOD_B0 = 16'h100A;
  localparam logic [15:0] HNC_OFS_PERIOD_B1 = 16'h100B;
  localparam logic [15:0] HNC_OFS_PERIOD_B2 = 16'h100C;
  localparam int HNC_NUM_REGS = 5;
  // ==========================================================
  // Reset values
  localparam logic [7:0] HNC_RST_CLAMP_HIGH = 8'hFF;
  localparam logic [7:0] HNC_RST_FILTER_BW = 8'h00;
  localparam logic [7:0] HNC_RST_PERIOD_B0 = 8'h0A;
  localparam logic [7:0] HNC_RST_PERIOD_B1 = 8'h00;
  localparam logic [7:0] HNC_RST_PERIOD_B2 = 8'h00;
  // ==========================================================
  // Field layout
  localparam int HNC_BW_LSB = 0;
  localparam int HNC_BW_WIDTH = 4;
  localparam int HNC_PERIOD_LOW_WIDTH = 24;
  // ==========================================================
  // Timing: one millisecond tick at 40 MHz
  localparam int HNC_CLK_HZ = 40000000;
  localparam int HNC_TICK_MS = 1;
  localparam int HNC_TICK_CYCLES = HNC_CLK_HZ / 1000 * HNC_TICK_MS;
  // Cutoff table in tenths of a hertz, one entry per code
  localparam logic [31:0] HNC_CUTOFF_DHZ [16] = '{
    32'h002625A0, 32'h00124F80, 32'h00097630, 32'h0004BAF0,
    32'h000270F0, 32'h00013098, 32'h0000984C, 32'h00004A38,
    32'h00002594, 32'h00001324, 32'h00000960, 32'h000004B0,
    32'h00000262, 32'h0000012C, 32'h00000096, 32'h0000004C};
endpackage

/* File: core/hnc_reg_if.sv */
`timescale 1ns/1ps
// Register byte access between the bank and its storage
interface hnc_reg_if;
  logic wr_en;
  logic [2:0] index;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bank (output wr_en, output index, output wdata, input rdata);
  modport store (input wr_en, input index, input wdata, output rdata);
endinterface

/* File: core/hnc_reg_store.sv */
`timescale 1ns/1ps
// Five byte registers with registered read data and flat view
module hnc_reg_store
  import hnc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  hnc_reg_if.store bus,
  output logic [8*HNC_NUM_REGS-1:0] flat
);
  // ==========================================================
  // Storage
  localparam logic [7:0] RST [HNC_NUM_REGS] = '{HNC_RST_CLAMP_HIGH, HNC_RST_FILTER_BW,
    HNC_RST_PERIOD_B0, HNC_RST_PERIOD_B1, HNC_RST_PERIOD_B2};
  logic [7:0] mem [HNC_NUM_REGS];
  logic [7:0] next_mem [HNC_NUM_REGS];
  logic [7:0] next_rdata;

  // Next values of each byte and of the read port
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < HNC_NUM_REGS; i++) begin
      next_mem[i] = mem[i];
      if (bus.wr_en && bus.index == 3'(i)) begin
        next_mem[i] = bus.wdata;
      end
      if (bus.index == 3'(i)) begin
        next_rdata = mem[i];
      end
    end
  end

  // Bytes reset to documented values, ten ms timer among them
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < HNC_NUM_REGS; i++) begin
      mem[i] <= reset ? RST[i] : next_mem[i];
    end
    bus.rdata <= reset ? 8'h00 : next_rdata;
  end

  generate
    for (genvar g = 0; g < HNC_NUM_REGS; g++) begin : g_flat
      assign flat[8*g +: 8] = mem[g];
    end
  endgenerate
endmodule

/* File: core/hnc_bank.sv */
`timescale 1ns/1ps
// Loop channel zero: clamp high byte, NCO filter code, history period
module hnc_bank
  import hnc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  input wire logic [15:0] clamp_low,
  output logic [23:0] clamp_value,
  output logic [3:0] filter_bw_code,
  output logic [31:0] filter_cutoff_dhz,
  output logic [27:0] history_period_ms,
  input wire logic [3:0] history_period_top,
  output logic history_period_done,
  output logic ms_tick
);
  // ==========================================================
  // Address decode
  function automatic logic [3:0] decode(input logic [15:0] a);
    if (a == HNC_OFS_CLAMP_HIGH) decode = 4'h8;
    else if (a == HNC_OFS_FILTER_BW) decode = 4'h9;
    else if (a == HNC_OFS_PERIOD_B0) decode = 4'hA;
    else if (a == HNC_OFS_PERIOD_B1) decode = 4'hB;
    else if (a == HNC_OFS_PERIOD_B2) decode = 4'hC;
    else decode = 4'h0;
  endfunction

  hnc_reg_if rif ();
  logic [8*HNC_NUM_REGS-1:0] flat;
  logic [3:0] hit;
  logic rd_q, next_rd_q;

  assign hit = decode(reg_addr);
  assign rif.wr_en = reg_wr && hit != 4'h0;
  // Unmapped addresses select slot 7, which holds nothing and reads as zero
  assign rif.index = hit[3] ? 3'(hit - 4'h8) : 3'h7;
  assign rif.wdata = reg_wdata;

  hnc_reg_store u_store (
    .sys_clk(sys_clk),
    .reset(reset),
    .bus(rif.store),
    .flat(flat)
  );

  // ==========================================================
  // Read answer one cycle after strobe; unmapped reads as zero
  always_comb begin
    next_rd_q = reg_rd;
  end
  always_ff @(posedge sys_clk) begin
    rd_q <= reset ? 1'b0 : next_rd_q;
  end
  // Read data comes straight from the store's output register
  assign reg_rdata = rif.rdata;
  assign reg_rvalid = rd_q;

  // ==========================================================
  // Field assembly, low byte at lowest address
  logic [23:0] next_clamp;
  logic [3:0] next_bw;
  logic [31:0] next_cut;
  logic [27:0] next_period;
  always_comb begin
    next_clamp = {flat[7:0], clamp_low};
    next_bw = flat[8 + HNC_BW_LSB +: HNC_BW_WIDTH];
    next_cut = HNC_CUTOFF_DHZ[next_bw];
    next_period = {history_period_top, flat[39:16]};
  end
  always_ff @(posedge sys_clk) begin
    clamp_value <= reset ? {HNC_RST_CLAMP_HIGH, 16'hFFFF} : next_clamp;
    filter_bw_code <= reset ? HNC_RST_FILTER_BW[3:0] : next_bw;
    filter_cutoff_dhz <= reset ? HNC_CUTOFF_DHZ[0] : next_cut;
    history_period_ms <= reset ? {4'h0, HNC_RST_PERIOD_B2, HNC_RST_PERIOD_B1, HNC_RST_PERIOD_B0} : next_period;
  end

  // ==========================================================
  // Millisecond divider and averaging period counter
  logic [15:0] div, next_div;
  logic [27:0] ms_cnt, next_ms_cnt;
  logic next_tick, next_done;
  always_comb begin
    next_tick = div == 16'(HNC_TICK_CYCLES - 1);
    next_div = next_tick ? 16'h0000 : div + 16'h0001;
    next_ms_cnt = ms_cnt;
    next_done = 1'b0;
    if (ms_tick) begin
      // Zero period is undefined; treated as one ms here
      if (ms_cnt + 28'h0000001 >= history_period_ms) begin
        next_ms_cnt = 28'h0000000;
        next_done = 1'b1;
      end else begin
        next_ms_cnt = ms_cnt + 28'h0000001;
      end
    end
  end
  always_ff @(posedge sys_clk) begin
    div <= reset ? 16'h0000 : next_div;
    ms_tick <= reset ? 1'b0 : next_tick;
    ms_cnt <= reset ? 28'h0000000 : next_ms_cnt;
    history_period_done <= reset ? 1'b0 : next_done;
  end
endmodule

/* File: tb/hnc_bank_asserts.sv */
`timescale 1ns/1ps
// ==========
// Port checker
module hnc_chk (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic [23:0] clamp_value,
  input wire logic [3:0] filter_bw_code,
  input wire logic [31:0] filter_cutoff_dhz,
  input wire logic [27:0] history_period_ms
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Writes land two cycles on, reads answer one cycle on
  a_rd_answer: assert property (reg_rd |=> reg_rvalid) else $error("no read answer");
  a_bw_follow: assert property (reg_wr && reg_addr == 16'h1009 |-> ##2
    {4'h0, filter_bw_code} == ($past(reg_wdata, 2) & 8'h0F)) else $error("bad code");
  a_cut_top: assert property (filter_bw_code == 4'h0 |-> filter_cutoff_dhz == 32'h002625A0)
    else $error("bad top cutoff");
  a_cut_floor: assert property (filter_bw_code == 4'hF |-> filter_cutoff_dhz == 32'h0000004C)
    else $error("bad floor cutoff");
  a_rst_vals: assert property ($fell(reset) |-> clamp_value[23:16] == 8'hFF &&
    filter_bw_code == 4'h0 && history_period_ms[23:0] == 24'h00000A) else $error("bad reset");
  a_period_mid: assert property (reg_wr && reg_addr == 16'h100B |-> ##2
    history_period_ms[15:8] == $past(reg_wdata, 2)) else $error("bad period");
  a_clamp_top: assert property (reg_wr && reg_addr == 16'h1008 |-> ##2
    clamp_value[23:16] == $past(reg_wdata, 2)) else $error("bad clamp");
  a_hole_zero: assert property (reg_rd && (reg_addr < 16'h1008 || reg_addr > 16'h100C) |=>
    reg_rdata == 8'h00) else $error("hole not zero");
  c_bw: cover property (reg_wr && reg_addr == 16'h1009);
  c_rd: cover property (reg_rvalid);
  c_low: cover property (filter_bw_code == 4'hF);
endmodule
bind hnc_bank hnc_chk chk_i (.*);

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
// ==========
// Bench for the channel zero bank
module tb_top import hnc_pkg::*;;
  logic sys_clk, reset = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0, reg_rvalid, ms_tick, history_period_done;
  logic [15:0] reg_addr = 16'h0, clamp_low = 16'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata, d, q[$], b[3];
  logic [7:0] rst_v[5] = '{8'hFF, 8'h00, 8'h0A, 8'h00, 8'h00};
  logic [3:0] history_period_top = 4'h0, filter_bw_code;
  logic [23:0] clamp_value;
  logic [31:0] filter_cutoff_dhz;
  logic [27:0] history_period_ms;
  int miscompares = 0, samples_checked = 0, seed = 32'hE83178FC, ticks = 0;
  realtime t0;
  hnc_bank uut (.*);
  initial begin
    sys_clk = 1'h0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // ==========
  // Checking and closing
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  task close_out;
    $display("checked %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // Each read answer is matched with the oldest note
  // Sampled at the falling edge, away from the edge that launches the answer
  always @(negedge sys_clk) if (reg_rvalid === 1'h1) chk(reg_rdata, q.pop_front());
  always @(negedge sys_clk) if (ms_tick === 1'h1) ticks++;
  initial begin
    #2_300_000 miscompares++;
    close_out();
  end
  // ==========
  // Bus tasks, strobes held across one rising edge
  task wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'h1, a, v};
    @(negedge sys_clk) reg_wr = 1'h0;
  endtask
  task rd(input logic [15:0] a, input logic [7:0] e);
    q.push_back(e);
    @(negedge sys_clk) {reg_rd, reg_addr} = {1'h1, a};
    @(negedge sys_clk) reg_rd = 1'h0;
  endtask
  initial begin
    repeat (2) @(negedge sys_clk);
    reset = 1'h0;
    foreach (rst_v[i]) rd(16'h1008 + 16'(i), rst_v[i]);
    chk(history_period_ms, 28'h000000A);
    wr(16'h100D, 8'h55);
    rd(16'h1007, 8'h00);
    rd(16'h100D, 8'h00);
    // Every filter code, with random reserved bits kept
    for (int c = 0; c < 16; c++) begin
      d = $random(seed);
      d[3:0] = c[3:0];
      wr(16'h1009, d);
      rd(16'h1009, d);
      chk(filter_bw_code, c);
      chk(filter_cutoff_dhz, HNC_CUTOFF_DHZ[c]);
    end
    clamp_low = $random(seed);
    history_period_top = $random(seed);
    foreach (b[i]) begin
      b[i] = $random(seed);
      if (i == 0) b[i][0] = 1'h1;
      wr(16'h100A + 16'(i), b[i]);
    end
    wr(16'h1008, b[1]);
    repeat (3) @(negedge sys_clk);
    chk(history_period_ms, {history_period_top, b[2], b[1], b[0]});
    chk(clamp_value, {b[1], clamp_low});
    // Fresh reset, then a one millisecond period measured between two ends
    reset = 1'h1;
    repeat (2) @(negedge sys_clk);
    reset = 1'h0;
    history_period_top = 4'h0;
    wr(16'h100A, 8'h01);
    @(posedge history_period_done) t0 = $realtime;
    ticks = 0;
    @(posedge history_period_done) chk(int'(($realtime - t0) / 25.0), 40000);
    chk(ticks, 1);
    close_out();
  end
endmodule
